/* File: hw/cmd_time_limit.sv */
// Completion time limit counter in microseconds with an expiry flag.
`timescale 1ns/10ps
module cmd_time_limit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [stream_read_pkg::LIMIT_W-1:0] limit_us,
  output logic expired_q
);
  logic [4:0] pre_q;
  logic [stream_read_pkg::LIMIT_W-1:0] left_q;
  logic run_q;

  // A zero limit means no limit, so the counter is never armed for it.
  always_ff @(posedge mclk)
  begin
    // The opcode write lands while the idle stop is still high, so start has to win over it.
    if (rst || (stop && !start))
    begin
      run_q <= 1'b0;
      pre_q <= 5'h00;
      left_q <= '0;
      expired_q <= 1'b0;
    end
    else if (start)
    begin
      run_q <= (limit_us != '0);
      pre_q <= 5'h00;
      left_q <= limit_us;
      expired_q <= 1'b0;
    end
    else if (run_q)
    begin
      if (pre_q == stream_read_pkg::US_LAST)
      begin
        pre_q <= 5'h00;
        if (left_q == stream_read_pkg::LIMIT_W'(1))
        begin
          expired_q <= 1'b1;
          run_q <= 1'b0;
        end
        left_q <= left_q - stream_read_pkg::LIMIT_W'(1);
      end
      else
      begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end
endmodule

/* File: hw/read_stream_dma_command.sv */
// Streaming DMA read command interpreter with APB taskfile, status, error log and interrupt.
//
// Notes on behaviour
// - Writing opcode 2Ah to the command register starts a streaming DMA read.
// - The device moves the number of sectors in the 16-bit sector count, from one to 65536.
// - A sector count of zero asks for 65536 sectors.
// - With the continuous-read bit clear the command runs in normal streaming mode and stops on an error.
// - With continuous-read set the full length is delivered unless the completion time limit expires first, and ERR is never set.
// - With continuous-read set SE goes to one whenever transferred data had errors.
// - With continuous-read set read or transfer errors never end the command early.
// - After errors in continuous-read mode ending status is BSY 0, SE 1, ERR 0 with the error type logged.
// - In continuous-read mode an expired completion time limit stops the command with SE 1, ERR 0 and CCTO logged.
// - With continuous-read set the device tries to move the full length before the completion time limit elapses.
// - Status holds BSY 7, RDY 6, SE 5, DWE 4, DRQ 3, ERR 0, with BSY and DWE zero at completion.
// - Bit 6 of the current feature byte selects continuous-read mode.
// - The low three bits of the current feature byte pick the stream identifier.
// - The limit is previous feature byte times the identify time unit in microseconds, zero using the stream default.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module read_stream_dma_command (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  output logic sec_req_q,
  output stream_read_pkg::sector_req_t sec_cmd_q,
  input wire logic sec_done,
  input wire stream_read_pkg::sector_err_t sec_err,
  output logic irq_q
);
  logic [7:0] feat_cur_q;
  logic [7:0] feat_prev_q;
  logic [15:0] count_q;
  logic [stream_read_pkg::LBA_W-1:0] lba_q;
  logic [7:0] device_q;
  logic [31:0] time_unit_q;
  logic [7:0] def_limit_q [stream_read_pkg::NUM_STREAMS];
  logic [stream_read_pkg::INT_W-1:0] int_stat_q;
  logic [stream_read_pkg::INT_W-1:0] int_stat_d;
  logic [stream_read_pkg::INT_W-1:0] int_en_q;

  stream_read_pkg::seq_state_t state_q;
  logic busy_q;
  logic rdy_q;
  logic se_q;
  logic err_q;
  logic [7:0] errlog_q;
  logic rc_q;
  logic [stream_read_pkg::COUNT_W-1:0] remain_q;
  logic [stream_read_pkg::LBA_W-1:0] cur_lba_q;
  logic [stream_read_pkg::SID_W-1:0] sid_q;
  logic done_q;

  logic wr_en;
  logic rd_phase;
  logic cmd_wr;
  logic start;
  logic bad_cmd;
  logic expired;
  logic stop_seq;
  logic [7:0] status_byte;
  logic [7:0] limit_byte;
  logic [stream_read_pkg::LIMIT_W-1:0] limit_us;
  logic [31:0] rd_data;
  logic rd_miss;
  logic sec_bad;
  logic [7:0] sec_bits;

  // One wait state lets read data and the answer come from flip-flops.
  assign rd_phase = psel && penable && !pready_q;
  assign wr_en = psel && penable && pready_q && pwrite;
  assign cmd_wr = wr_en && (paddr == stream_read_pkg::OFS_COMMAND);
  // A command written while busy is ignored; only the opcode write starts work.
  assign start = cmd_wr && !busy_q && (pwdata[7:0] == stream_read_pkg::OPC_READ_STREAM_DMA);
  assign bad_cmd = cmd_wr && !busy_q && (pwdata[7:0] != stream_read_pkg::OPC_READ_STREAM_DMA);

  assign sec_bad = sec_err.icrc || sec_err.unc || sec_err.idnf || sec_err.abrt;

  always_comb
  begin
    sec_bits = 8'h00;
    sec_bits[stream_read_pkg::ER_ICRC] = sec_err.icrc;
    sec_bits[stream_read_pkg::ER_UNC] = sec_err.unc;
    sec_bits[stream_read_pkg::ER_IDNF] = sec_err.idnf;
    sec_bits[stream_read_pkg::ER_ABRT] = sec_err.abrt;
  end

  // The limit is only enforced when continuous-read is on; normal mode ends on its own errors.
  assign stop_seq = busy_q && rc_q && expired;

  always_comb
  begin
    // A zero previous feature byte falls back to the stream default; a zero default disables the limit.
    limit_byte = (feat_prev_q != 8'h00) ? feat_prev_q : def_limit_q[feat_cur_q[stream_read_pkg::SID_W-1:0]];
    limit_us = stream_read_pkg::LIMIT_W'(limit_byte) * stream_read_pkg::LIMIT_W'(time_unit_q);
  end

  cmd_time_limit u_limit (
    .mclk(mclk),
    .rst(rst),
    .start(start),
    .stop(!busy_q),
    .limit_us(limit_us),
    .expired_q(expired)
  );

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[stream_read_pkg::ST_BSY] = busy_q;
    status_byte[stream_read_pkg::ST_RDY] = rdy_q;
    status_byte[stream_read_pkg::ST_SE] = se_q;
    status_byte[stream_read_pkg::ST_DWE] = 1'b0;
    status_byte[stream_read_pkg::ST_DRQ] = busy_q;
    status_byte[stream_read_pkg::ST_ERR] = err_q;
  end

  // Taskfile and configuration registers.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      feat_cur_q <= 8'h00;
      feat_prev_q <= 8'h00;
      count_q <= 16'h0000;
      lba_q <= '0;
      device_q <= 8'h00;
      time_unit_q <= 32'h00000000;
      int_en_q <= '0;
      for (int i = 0; i < stream_read_pkg::NUM_STREAMS; i++)
      begin
        def_limit_q[i] <= 8'h00;
      end
    end
    else if (wr_en && !busy_q)
    begin
      case (paddr)
        stream_read_pkg::OFS_FEATURE:
        begin
          feat_cur_q <= pwdata[7:0];
          feat_prev_q <= pwdata[15:8];
        end
        stream_read_pkg::OFS_SECCOUNT: count_q <= pwdata[15:0];
        stream_read_pkg::OFS_LBA_LO: lba_q[31:0] <= pwdata;
        stream_read_pkg::OFS_LBA_HI: lba_q[47:32] <= pwdata[15:0];
        stream_read_pkg::OFS_DEVICE: device_q <= pwdata[7:0];
        stream_read_pkg::OFS_TIME_UNIT: time_unit_q <= pwdata;
        stream_read_pkg::OFS_INT_ENABLE: int_en_q <= pwdata[stream_read_pkg::INT_W-1:0];
        default:
        begin
          if (paddr >= stream_read_pkg::OFS_DEF_LIMIT && paddr <= stream_read_pkg::OFS_DEF_LIMIT_END
              && paddr[1:0] == 2'h0)
          begin
            def_limit_q[paddr[4:2]] <= pwdata[7:0];
          end
        end
      endcase
    end
    else if (wr_en && paddr == stream_read_pkg::OFS_INT_ENABLE)
    begin
      int_en_q <= pwdata[stream_read_pkg::INT_W-1:0];
    end
  end

  // Sector sequencer: one DMA sector request at a time until the count is used up.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= stream_read_pkg::SEQ_IDLE;
      busy_q <= 1'b0;
      rdy_q <= 1'b1;
      se_q <= 1'b0;
      err_q <= 1'b0;
      errlog_q <= 8'h00;
      rc_q <= 1'b0;
      remain_q <= '0;
      cur_lba_q <= '0;
      sid_q <= '0;
      sec_req_q <= 1'b0;
      sec_cmd_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      sec_req_q <= 1'b0;
      done_q <= 1'b0;
      if (bad_cmd)
      begin
        err_q <= 1'b1;
        se_q <= 1'b0;
        errlog_q <= 8'h00;
        errlog_q[stream_read_pkg::ER_ABRT] <= 1'b1;
        done_q <= 1'b1;
      end
      else if (start)
      begin
        busy_q <= 1'b1;
        se_q <= 1'b0;
        err_q <= 1'b0;
        errlog_q <= 8'h00;
        rc_q <= feat_cur_q[stream_read_pkg::FEAT_RC_BIT];
        sid_q <= feat_cur_q[stream_read_pkg::SID_W-1:0];
        // A zero count widens to the full 65536 sectors.
        remain_q <= (count_q == 16'h0000) ? stream_read_pkg::MAX_SECTORS : {1'b0, count_q};
        cur_lba_q <= lba_q;
        state_q <= stream_read_pkg::SEQ_ISSUE;
      end
      else if (stop_seq)
      begin
        // Ending on the limit keeps ERR clear and flags the stream error.
        busy_q <= 1'b0;
        se_q <= 1'b1;
        err_q <= 1'b0;
        errlog_q[stream_read_pkg::ER_CCTO] <= 1'b1;
        done_q <= 1'b1;
        state_q <= stream_read_pkg::SEQ_IDLE;
      end
      else
      begin
        case (state_q)
          stream_read_pkg::SEQ_IDLE:
          begin
            busy_q <= 1'b0;
          end
          stream_read_pkg::SEQ_ISSUE:
          begin
            sec_req_q <= 1'b1;
            sec_cmd_q.lba <= cur_lba_q;
            sec_cmd_q.stream <= sid_q;
            state_q <= stream_read_pkg::SEQ_WAIT;
          end
          stream_read_pkg::SEQ_WAIT:
          begin
            if (sec_done)
            begin
              if (sec_bad && !rc_q)
              begin
                // Normal mode terminates at the failing sector.
                busy_q <= 1'b0;
                err_q <= 1'b1;
                errlog_q <= sec_bits;
                done_q <= 1'b1;
                state_q <= stream_read_pkg::SEQ_IDLE;
              end
              else
              begin
                if (sec_bad)
                begin
                  se_q <= 1'b1;
                  errlog_q <= errlog_q | sec_bits;
                end
                // Continuous mode keeps going, so the full length is attempted.
                remain_q <= remain_q - stream_read_pkg::COUNT_W'(1);
                cur_lba_q <= cur_lba_q + stream_read_pkg::LBA_W'(1);
                if (remain_q == stream_read_pkg::COUNT_W'(1))
                begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  state_q <= stream_read_pkg::SEQ_IDLE;
                end
                else
                begin
                  state_q <= stream_read_pkg::SEQ_ISSUE;
                end
              end
            end
          end
          default:
          begin
            state_q <= stream_read_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // Sticky interrupt status; an event in the clearing cycle survives the clear.
  always_comb
  begin
    int_stat_d = int_stat_q;
    if (wr_en && paddr == stream_read_pkg::OFS_INT_CLEAR)
    begin
      int_stat_d = int_stat_d & ~pwdata[stream_read_pkg::INT_W-1:0];
    end
    if (done_q)
    begin
      int_stat_d[stream_read_pkg::INT_DONE] = 1'b1;
      int_stat_d[stream_read_pkg::INT_STREAM_ERR] = int_stat_q[stream_read_pkg::INT_STREAM_ERR] | se_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      int_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_d & int_en_q);
    end
  end

  // Read multiplexer and unmapped-address detection.
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_miss = 1'b0;
    case (paddr)
      stream_read_pkg::OFS_FEATURE: rd_data = {16'h0000, feat_prev_q, feat_cur_q};
      stream_read_pkg::OFS_SECCOUNT: rd_data = {16'h0000, count_q};
      stream_read_pkg::OFS_LBA_LO: rd_data = lba_q[31:0];
      stream_read_pkg::OFS_LBA_HI: rd_data = {16'h0000, lba_q[47:32]};
      stream_read_pkg::OFS_DEVICE: rd_data = {24'h000000, device_q};
      stream_read_pkg::OFS_COMMAND: rd_data = 32'h00000000;
      stream_read_pkg::OFS_STATUS: rd_data = {24'h000000, status_byte};
      stream_read_pkg::OFS_ERROR: rd_data = {24'h000000, errlog_q};
      stream_read_pkg::OFS_TIME_UNIT: rd_data = time_unit_q;
      stream_read_pkg::OFS_INT_STATUS: rd_data = {30'h00000000, int_stat_q};
      stream_read_pkg::OFS_INT_CLEAR: rd_data = 32'h00000000;
      stream_read_pkg::OFS_INT_ENABLE: rd_data = {30'h00000000, int_en_q};
      stream_read_pkg::OFS_REMAIN: rd_data = {15'h0000, remain_q};
      default:
      begin
        if (paddr >= stream_read_pkg::OFS_DEF_LIMIT && paddr <= stream_read_pkg::OFS_DEF_LIMIT_END
            && paddr[1:0] == 2'h0)
        begin
          rd_data = {24'h000000, def_limit_q[paddr[4:2]]};
        end
        else
        begin
          rd_miss = 1'b1;
        end
      end
    endcase
    if (paddr[1:0] != 2'h0)
    begin
      rd_miss = 1'b1;
      rd_data = 32'h00000000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (rd_phase)
    begin
      pready_q <= 1'b1;
      pslverr_q <= rd_miss;
      prdata_q <= pwrite ? 32'h00000000 : rd_data;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
  end
endmodule

/* File: hw/stream_read_pkg.sv */
// Package with register map, field positions, timing constants and carrier types for the stream read block.
package stream_read_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFS_FEATURE = 8'h00;
  localparam logic [7:0] OFS_SECCOUNT = 8'h04;
  localparam logic [7:0] OFS_LBA_LO = 8'h08;
  localparam logic [7:0] OFS_LBA_HI = 8'h0c;
  localparam logic [7:0] OFS_DEVICE = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ERROR = 8'h1c;
  localparam logic [7:0] OFS_TIME_UNIT = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS = 8'h24;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h28;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h2c;
  localparam logic [7:0] OFS_REMAIN = 8'h30;
  localparam logic [7:0] OFS_DEF_LIMIT = 8'h40;
  localparam logic [7:0] OFS_DEF_LIMIT_END = 8'h5c;

  localparam logic [7:0] OPC_READ_STREAM_DMA = 8'h2a;

  // Current feature byte fields.
  localparam int FEAT_RC_BIT = 6;
  localparam int SID_W = 3;
  localparam int NUM_STREAMS = 8;

  // Status byte positions.
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SE = 5;
  localparam int ST_DWE = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;

  // Error byte positions.
  localparam int ER_ICRC = 7;
  localparam int ER_UNC = 6;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  localparam int ER_CCTO = 0;

  // Interrupt status positions.
  localparam int INT_DONE = 0;
  localparam int INT_STREAM_ERR = 1;
  localparam int INT_W = 2;

  localparam logic [16:0] MAX_SECTORS = 17'h10000;
  localparam int COUNT_W = 17;
  localparam int LBA_W = 48;
  localparam int LIMIT_W = 40;

  // One limit unit is a microsecond; the prescaler counts mclk periods into it.
  localparam int MCLK_PERIOD_NS = 40;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [4:0] US_LAST = 5'(CYC_PER_US - 1);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_state_t;

  typedef struct packed {
    logic icrc;
    logic unc;
    logic idnf;
    logic abrt;
  } sector_err_t;

  typedef struct packed {
    logic [LBA_W-1:0] lba;
    logic [SID_W-1:0] stream;
  } sector_req_t;

endpackage

/* File: test/read_stream_dma_command_props.sv */
// Checker for bus timing, sector requests and status layout of the stream read block.
`timescale 1ns/10ps
module read_stream_dma_command_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic sec_req_q,
  input wire stream_read_pkg::sector_req_t sec_cmd_q,
  input wire logic sec_done,
  input wire stream_read_pkg::sector_err_t sec_err,
  input wire logic irq_q
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence cmd_write;
    pready_q && pwrite && paddr == stream_read_pkg::OFS_COMMAND &&
      pwdata[7:0] == stream_read_pkg::OPC_READ_STREAM_DMA;
  endsequence
  sequence rd_at(logic [7:0] a);
    psel && pready_q && !pwrite && paddr == a;
  endsequence

  chk_ready_wait: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("ready late");
  chk_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready held");
  chk_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("read data outside answer");
  chk_slverr_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  chk_cmd_start: assert property (cmd_write |-> ##2 sec_req_q)
    else $error("no sector request after start");
  chk_req_pulse: assert property (sec_req_q |=> !sec_req_q ##1 !sec_req_q)
    else $error("request too long");
  chk_cmd_stable: assert property (!sec_req_q |-> $stable(sec_cmd_q))
    else $error("sector command moved");
  chk_status_bits: assert property (rd_at(stream_read_pkg::OFS_STATUS) |->
    prdata_q[31:8] == 24'h0 && !prdata_q[stream_read_pkg::ST_DWE] &&
    prdata_q[stream_read_pkg::ST_DRQ] == prdata_q[stream_read_pkg::ST_BSY])
    else $error("status layout");
  chk_se_err_apart: assert property (rd_at(stream_read_pkg::OFS_STATUS) |->
    !(prdata_q[stream_read_pkg::ST_SE] && prdata_q[stream_read_pkg::ST_ERR]))
    else $error("stream error with error bit");
  chk_error_bits: assert property (rd_at(stream_read_pkg::OFS_ERROR) |->
    prdata_q[31:8] == 24'h0 && !prdata_q[5] && !prdata_q[3] && !prdata_q[1])
    else $error("error byte layout");
  chk_irq_clear: assert property (pready_q && pwrite && paddr == stream_read_pkg::OFS_INT_CLEAR &&
    pwdata[1:0] == 2'h3 |-> ##2 !irq_q)
    else $error("interrupt not cleared");
endmodule

bind read_stream_dma_command read_stream_dma_command_props chk_u (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .sec_req_q(sec_req_q), .sec_cmd_q(sec_cmd_q),
  .sec_done(sec_done), .sec_err(sec_err), .irq_q(irq_q));

/* File: test/sector_responder.sv */
// Behavioural media and DMA side that answers each sector request.
`timescale 1ns/10ps
module sector_responder (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sec_req,
  input wire stream_read_pkg::sector_req_t sec_cmd,
  input wire logic [2:0] dly,
  input wire logic [47:0] err_lba,
  input wire stream_read_pkg::sector_err_t err_kind,
  output logic sec_done = 1'b0,
  output stream_read_pkg::sector_err_t sec_err = '0
);
  logic busy_q = 1'b0;
  logic [2:0] cnt_q = 3'h0;
  logic [47:0] lba_q = 48'h0;

  // Error lines toggle outside the done cycle, so early sampling picks up garbage.
  always @(posedge mclk)
  begin
    sec_done <= 1'b0;
    sec_err <= ~sec_err;
    if (rst)
      busy_q <= 1'b0;
    else if (sec_req)
    begin
      busy_q <= 1'b1;
      cnt_q <= dly;
      lba_q <= sec_cmd.lba;
    end
    else if (busy_q && cnt_q == 3'h0)
    begin
      busy_q <= 1'b0;
      sec_done <= 1'b1;
      sec_err <= (lba_q == err_lba) ? err_kind : '0;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the stream read command block.
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sec_req_q;
  stream_read_pkg::sector_req_t sec_cmd_q;
  logic sec_done;
  stream_read_pkg::sector_err_t sec_err;
  logic irq_q;
  logic [2:0] dly = 3'h1;
  logic [47:0] err_lba = 48'h0;
  stream_read_pkg::sector_err_t err_kind = '0;
  logic [31:0] seed = 32'h11;
  logic [47:0] exp_lba = 48'h0;
  logic [2:0] exp_sid = 3'h0;
  int failures = 0;
  int tests_run = 0;
  int nreq = 0;
  int ndone = 0;
  logic [31:0] rv;
  logic ev;
  int cyc = 0;
  int t_cmd = 0;
  int lim_cyc = 0;

  always #20 mclk = ~mclk;

  read_stream_dma_command dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .sec_req_q(sec_req_q), .sec_cmd_q(sec_cmd_q), .sec_done(sec_done), .sec_err(sec_err), .irq_q(irq_q));
  sector_responder far_u (.mclk(mclk), .rst(rst), .sec_req(sec_req_q), .sec_cmd(sec_cmd_q), .dly(dly),
    .err_lba(err_lba), .err_kind(err_kind), .sec_done(sec_done), .sec_err(sec_err));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The master holds every request signal until the edge that samples ready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready_q !== 1'b1 && n < 20);
    if (n == 20)
      failures++;
    rv = prdata_q;
    ev = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rv, exp);
  endtask

  task automatic finish_chk(input logic [7:0] st, input logic [7:0] eb, input logic [1:0] en);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, stream_read_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    while (rv[7] !== 1'b0 && n < 3000);
    check(rv, {24'h0, st});
    rd(stream_read_pkg::OFS_ERROR, {24'h0, eb});
    rd(stream_read_pkg::OFS_INT_STATUS, {30'h0, st[5], 1'b1});
    check(irq_q, |({st[5], 1'b1} & en));
    wr(stream_read_pkg::OFS_INT_CLEAR, 32'h3);
    repeat (2) @(posedge mclk);
    check(irq_q, 1'b0);
  endtask

  // Model of one command: sectors moved, ending status and error byte follow from mode and fault.
  task automatic run_cmd(input logic [15:0] feat, input logic [15:0] cnt, input int eo,
    input stream_read_pkg::sector_err_t ek, input logic [1:0] en, input logic to);
    int n;
    int moved;
    logic [47:0] lba;
    logic rc;
    logic hit;
    lba = {16'(xs()), xs()};
    n = (cnt == 16'h0) ? 65536 : cnt;
    rc = feat[stream_read_pkg::FEAT_RC_BIT];
    hit = (ek != '0);
    moved = (hit && !rc) ? eo + 1 : n;
    // A timed-out run uses default limit 1 times time unit 2; dones after expiry are dropped by the block.
    lim_cyc = to ? 1 * 2 * stream_read_pkg::CYC_PER_US : 0;
    err_lba <= lba + 48'(eo);
    err_kind <= ek;
    exp_lba <= lba;
    exp_sid <= feat[2:0];
    nreq <= 0;
    ndone <= 0;
    wr(stream_read_pkg::OFS_INT_ENABLE, {30'h0, en});
    wr(stream_read_pkg::OFS_FEATURE, {16'h0, feat});
    wr(stream_read_pkg::OFS_SECCOUNT, {16'h0, cnt});
    wr(stream_read_pkg::OFS_LBA_LO, lba[31:0]);
    wr(stream_read_pkg::OFS_LBA_HI, {16'h0, lba[47:32]});
    wr(stream_read_pkg::OFS_COMMAND, 32'h2a);
    t_cmd = cyc;
    finish_chk((rc && (hit || to)) ? 8'h60 : (hit ? 8'h41 : 8'h40),
      {ek.icrc, ek.unc, 1'b0, ek.idnf, 1'b0, ek.abrt, 1'b0, to}, en);
    if (!to)
      check(nreq, moved);
    if (!hit || rc)
      rd(stream_read_pkg::OFS_REMAIN, n - ndone);
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (sec_done === 1'b1 && (lim_cyc == 0 || cyc - t_cmd <= lim_cyc))
      ndone <= ndone + 1;
    if (sec_req_q === 1'b1)
    begin
      check(sec_cmd_q.lba, exp_lba);
      check(sec_cmd_q.stream, exp_sid);
      exp_lba <= exp_lba + 48'h1;
      nreq <= nreq + 1;
      dly <= 3'(xs());
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(stream_read_pkg::OFS_STATUS, 32'h40);
    apb(1'b0, 8'h38, 32'h0);
    check(ev, 1'b1);
    wr(stream_read_pkg::OFS_TIME_UNIT, 32'h2);
    wr(stream_read_pkg::OFS_DEF_LIMIT + 8'h14, 32'h1);
    // A misaligned write must not reach the default limit, or the timed-out run below would hang.
    apb(1'b1, stream_read_pkg::OFS_DEF_LIMIT + 8'h15, 32'h0);
    check(ev, 1'b1);
    wr(stream_read_pkg::OFS_DEVICE, 32'h40);
    rd(stream_read_pkg::OFS_DEVICE, 32'h40);
    // Normal mode ignores a limit shorter than the transfer.
    run_cmd(16'h0101, 16'h10, 0, '0, 2'h3, 1'b0);
    run_cmd(16'h0002, 16'h4, 1, 4'h4, 2'h1, 1'b0);
    run_cmd(16'h0043, 16'h4, 2, 4'ha, 2'h2, 1'b0);
    run_cmd(16'h2044, 16'h3, 0, 4'h1, 2'h0, 1'b0);
    run_cmd(16'h0045, 16'h0, 0, '0, 2'h3, 1'b1);
    wr(stream_read_pkg::OFS_COMMAND, 32'h20);
    finish_chk(8'h41, 8'h04, 2'h1);
    tally_and_finish();
  end
endmodule
